/* config_integrity_crc_checker.sv */
// Function
// [R1] Bad write checksum sets checksum error flag
// [R2] Host verifies writes by checked readback
// [R3] Memory CRC skips read-only locations
// [R4] Memory check repeats every 426.6 us
// [R5] Writes and calibration stores refresh reference
// [R6] Single-to-idle mode change refreshes reference
// [R7] Leaving streaming readout refreshes reference
// [R8] Memory check enable gates mismatch flag
// [R9] ROM check always runs after power-up
// [R10] ROM enable only gates ROM fault flag
// [R11] Checksum enable bit 2, resets cleared
`timescale 1ns/1ps
`default_nettype none
module config_integrity_crc_checker #(
    parameter int CHECK_CYC = crc_check_pkg::CHECK_CYCLES,
    parameter int LOCS = crc_check_pkg::MEM_LOCS,
    parameter int ROM_LEN = crc_check_pkg::ROM_WORDS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register writes from the serial framing logic
    input wire logic wr_valid,
    input wire logic [crc_check_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [crc_check_pkg::DATA_W-1:0] wr_data,
    input wire logic [crc_check_pkg::CRC_W-1:0] wr_checksum,
    // Memory-map update sources
    input wire logic cal_store,
    input wire logic [crc_check_pkg::MODE_W-1:0] mode,
    input wire logic streaming_readout_bit,
    // Memory-map scan port
    output logic [crc_check_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [crc_check_pkg::DATA_W-1:0] mem_rd_data,
    input wire logic mem_rd_ro,
    // ROM scan port
    output logic [crc_check_pkg::ADDR_W-1:0] rom_addr,
    input wire logic [crc_check_pkg::DATA_W-1:0] rom_data,
    input wire logic [crc_check_pkg::CRC_W-1:0] rom_expected_crc,
    // Error register interface
    input wire logic [2:0] err_clear,
    output logic [crc_check_pkg::DATA_W-1:0] error_check_enables,
    output logic spi_checksum_fault,
    output logic config_memory_fault_flag,
    output logic rom_fault_flag
);
    import crc_check_pkg::*;

    localparam int TW = $clog2(CHECK_CYC + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(CHECK_CYC - 1);
    localparam logic [ADDR_W-1:0] MEM_LAST = ADDR_W'(LOCS - 1);
    localparam logic [ADDR_W-1:0] ROM_LAST = ADDR_W'(ROM_LEN - 1);

    scan_state_t state;
    scan_state_t next_state;
    logic [ADDR_W-1:0] scan_addr;
    logic [TW-1:0] timer;
    logic [CRC_W-1:0] ref_crc;
    logic [MODE_W-1:0] mode_prev;
    logic stream_prev;
    logic upd_pending;
    logic chk_pending;
    logic rom_bad;
    logic rom_done;
    logic [CRC_W-1:0] acc_crc;

    // Write checksum decode
    wire [CRC_W-1:0] wr_calc = crc8_word(CRC_INIT, {wr_addr, wr_data});
    wire wr_bad = wr_calc != wr_checksum;
    wire spi_en = error_check_enables[SPI_EN_BIT];
    wire mm_en = error_check_enables[MM_EN_BIT];
    wire rom_en = error_check_enables[ROM_EN_BIT];
    // With checking on, a corrupted write must not reach the enables
    wire wr_take = wr_valid && !(spi_en && wr_bad);
    wire en_write = wr_take && (wr_addr == ENABLES_ADDR);

    // Update events that make the reference stale
    wire single_to_idle = (mode_prev == MODE_SINGLE) && (mode == MODE_IDLE);
    wire stream_exit = stream_prev && !streaming_readout_bit;
    wire upd_event = wr_take || cal_store || single_to_idle || stream_exit;

    // Scan decode
    wire in_rom = state == ST_ROM;
    wire in_mem = (state == ST_REF) || (state == ST_CHK);
    wire at_last = in_rom ? (scan_addr == ROM_LAST) : (scan_addr == MEM_LAST);
    wire acc_step = in_rom || (in_mem && !mem_rd_ro); // [R3]
    wire [DATA_W-1:0] acc_data = in_rom ? rom_data : mem_rd_data;
    wire acc_clear = (state == ST_IDLE) || (state == ST_ROM_END)
        || (state == ST_REF_END) || (state == ST_CHK_END);
    wire timer_hit = mm_en && (timer == TIMER_LAST);
    wire mismatch = acc_crc != ref_crc;
    wire mm_report = (state == ST_CHK_END) && mismatch && mm_en;
    wire rom_report = rom_done && rom_bad && rom_en;

    crc_scan_acc u_acc (
        .clk(clk),
        .rst(rst),
        .clear(acc_clear),
        .step(acc_step),
        .word({scan_addr, acc_data}),
        .crc(acc_crc)
    );

    // A fresh update aborts a running check so stale data never flags
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (upd_pending || upd_event) begin
                    next_state = ST_REF;
                end else if (chk_pending && mm_en) begin
                    next_state = ST_CHK;
                end
            end
            ST_ROM: begin
                if (at_last) begin
                    next_state = ST_ROM_END;
                end
            end
            ST_ROM_END: next_state = ST_IDLE;
            ST_REF: begin
                if (at_last) begin
                    next_state = ST_REF_END;
                end
            end
            ST_REF_END: next_state = ST_IDLE;
            ST_CHK: begin
                if (upd_event) begin
                    next_state = ST_IDLE;
                end else if (at_last) begin
                    next_state = ST_CHK_END;
                end
            end
            ST_CHK_END: next_state = ST_IDLE;
        endcase
    end

    wire scan_reset = next_state != state;
    wire [ADDR_W-1:0] next_scan_addr = scan_reset ? '0 : scan_addr + 8'h01;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_ROM; // [R9]
            scan_addr <= '0;
            rom_done <= 1'b0;
            rom_bad <= 1'b0;
        end else begin
            state <= next_state;
            scan_addr <= next_scan_addr;
            if (state == ST_ROM_END) begin
                rom_done <= 1'b1; // [R9]
                rom_bad <= acc_crc != rom_expected_crc;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_prev <= MODE_IDLE;
            stream_prev <= 1'b0;
            upd_pending <= 1'b1;
            ref_crc <= CRC_INIT;
        end else begin
            mode_prev <= mode;
            stream_prev <= streaming_readout_bit;
            if (upd_event) begin
                upd_pending <= 1'b1; // [R5] [R6] [R7]
            end else if (state == ST_IDLE && next_state == ST_REF) begin
                upd_pending <= 1'b0;
            end
            if (state == ST_REF_END) begin
                ref_crc <= acc_crc; // [R5]
            end
        end
    end

    // Period timer runs only while the memory check is enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer <= '0;
            chk_pending <= 1'b0;
        end else begin
            timer <= (!mm_en || timer_hit) ? '0 : timer + 1'b1; // [R4]
            if (timer_hit) begin
                chk_pending <= 1'b1; // [R4]
            end else if (state == ST_IDLE && next_state == ST_CHK) begin
                chk_pending <= 1'b0;
            end
        end
    end

    // Sticky flags: a set in the clear cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            error_check_enables <= ENABLES_RESET; // [R8] [R10] [R11]
            spi_checksum_fault <= 1'b0;
            config_memory_fault_flag <= 1'b0;
            rom_fault_flag <= 1'b0;
        end else begin
            if (en_write) begin
                error_check_enables <= wr_data;
            end
            spi_checksum_fault <= (wr_valid && spi_en && wr_bad) // [R1]
                || (spi_checksum_fault && !err_clear[CLR_SPI]);
            config_memory_fault_flag <= mm_report // [R8]
                || (config_memory_fault_flag && !err_clear[CLR_MM]);
            rom_fault_flag <= rom_report // [R10]
                || (rom_fault_flag && !err_clear[CLR_ROM]);
        end
    end

    assign mem_addr = scan_addr;
    assign rom_addr = scan_addr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_checksum_flag_set: assert property ( // [R1]
        wr_valid && spi_en && wr_bad |=> spi_checksum_fault)
        else $error("checksum fault not flagged");
    a_checksum_off_quiet: assert property ( // [R11]
        $rose(spi_checksum_fault) |-> $past(spi_en) && $past(wr_valid))
        else $error("checksum fault without enabled write");
    a_ro_skipped: assert property ( // [R3]
        in_mem && mem_rd_ro && !acc_clear |=> $stable(acc_crc))
        else $error("read-only location entered the crc");
    a_period_bound: assert property ( // [R4]
        timer <= TIMER_LAST)
        else $error("check timer overran its interval");
    a_period_request: assert property ( // [R4]
        timer_hit && state == ST_IDLE && !upd_pending && !upd_event
        |=> ##1 state == ST_CHK || upd_pending)
        else $error("periodic check not started");
    a_update_refresh: assert property ( // [R5]
        wr_take && state == ST_IDLE |=> state == ST_REF)
        else $error("write did not start a reference scan");
    a_single_idle: assert property ( // [R6]
        $past(mode) == MODE_SINGLE && mode == MODE_IDLE
        |=> upd_pending || state == ST_REF)
        else $error("single-to-idle did not mark update");
    a_stream_exit: assert property ( // [R7]
        $fell(streaming_readout_bit) |=> upd_pending || state == ST_REF)
        else $error("streaming exit did not mark update");
    a_mm_gated: assert property ( // [R8]
        $rose(config_memory_fault_flag) |-> $past(mm_en) && $past(mismatch))
        else $error("memory fault raised while disabled");
    a_rom_first: assert property ( // [R9]
        !rom_done |-> state == ST_ROM || state == ST_ROM_END)
        else $error("scan ran before the rom check");
    a_rom_gated: assert property ( // [R10]
        rom_done && rom_bad && rom_en |=> rom_fault_flag)
        else $error("rom fault not reported");

    c_checksum_fault: cover property (wr_valid && spi_en && wr_bad);
    c_mm_mismatch: cover property (mm_report);
    c_check_abort: cover property (state == ST_CHK && upd_event);
    c_rom_report: cover property ($rose(rom_fault_flag));
endmodule // config_integrity_crc_checker
`default_nettype wire

/* crc_check_pkg.sv */
`default_nettype none
package crc_check_pkg;
    localparam int DATA_W = 24;
    localparam int ADDR_W = 8;
    localparam int CRC_W = 8;
    localparam int WORD_W = ADDR_W + DATA_W;
    localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
    localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;
    // Error-enable register location and layout
    localparam logic [ADDR_W-1:0] ENABLES_ADDR = 8'h07;
    localparam logic [DATA_W-1:0] ENABLES_RESET = 24'h000040;
    localparam int ROM_EN_BIT = 0;
    localparam int MM_EN_BIT = 1;
    localparam int SPI_EN_BIT = 2;
    // Clear-strobe bit positions
    localparam int CLR_SPI = 0;
    localparam int CLR_MM = 1;
    localparam int CLR_ROM = 2;
    // Conversion mode field
    localparam int MODE_W = 4;
    localparam logic [MODE_W-1:0] MODE_SINGLE = 4'h1;
    localparam logic [MODE_W-1:0] MODE_IDLE = 4'h4;
    // Background check interval
    localparam real CHECK_INTERVAL_US = 426.6;
    localparam real CLK_FREQ_MHZ = 100.0;
    localparam int CHECK_CYCLES = int'($floor(CHECK_INTERVAL_US * CLK_FREQ_MHZ));
    localparam int MEM_LOCS = 64;
    localparam int ROM_WORDS = 32;

    typedef enum {
        ST_IDLE, ST_ROM, ST_ROM_END, ST_REF, ST_REF_END, ST_CHK, ST_CHK_END
    } scan_state_t;

    // Bitwise CRC-8 over one address/data word, MSB first
    function automatic logic [CRC_W-1:0] crc8_word(
        input logic [CRC_W-1:0] crc_in,
        input logic [WORD_W-1:0] word
    );
        logic [CRC_W-1:0] c;
        c = crc_in;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            c = (c[CRC_W-1] ^ word[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction
endpackage
`default_nettype wire

/* crc_scan_acc.sv */
`timescale 1ns/1ps
`default_nettype none
module crc_scan_acc (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Accumulation control
    input wire logic clear,
    input wire logic step,
    input wire logic [crc_check_pkg::WORD_W-1:0] word,
    // Running result
    output logic [crc_check_pkg::CRC_W-1:0] crc
);
    import crc_check_pkg::*;

    wire [CRC_W-1:0] next_crc = clear ? CRC_INIT :
        (step ? crc8_word(crc, word) : crc);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crc <= CRC_INIT;
        end else begin
            crc <= next_crc;
        end
    end
endmodule // crc_scan_acc
`default_nettype wire

/* host_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_mem_model #(
    parameter int ROM_LEN = 4
) (
    // Clock
    input wire logic clk,
    // Scan addresses
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] rom_addr,
    // Fault injection
    input wire logic [23:0] corrupt,
    input wire logic rom_bad,
    // Answers
    output logic [23:0] mem_rd_data,
    output logic mem_rd_ro,
    output logic [23:0] rom_data,
    output logic [7:0] rom_expected_crc
);
    logic [23:0] ro_cnt = 24'h000000;
    logic [7:0] g;
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h07) : (c << 1);
        end
        return c;
    endfunction
    // Status-like word moves every cycle, so scanning it would mismatch
    always @(posedge clk) ro_cnt <= ro_cnt + 24'h000001;
    assign mem_rd_ro = (mem_addr == 8'h03);
    assign mem_rd_data = mem_rd_ro ? ro_cnt : ({16'h5A00, mem_addr}
        ^ ((mem_addr == 8'h05) ? corrupt : 24'h000000));
    assign rom_data = {16'hC300, rom_addr} ^ {23'h000000, rom_bad};
    always_comb begin
        g = 8'h00;
        for (int a = 0; a < ROM_LEN; a++) begin
            g = crc8(g, {8'(a), 16'hC300, 8'(a)});
        end
        rom_expected_crc = g;
    end
endmodule // host_mem_model
`default_nettype wire

/* tb_config_integrity_crc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_config_integrity_crc_checker;
    import crc_check_pkg::*;
    localparam int CYC = 50;
    localparam int LC = 8;
    localparam int WAITC = 2 * (CYC + LC) + 30;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_valid = 1'b0;
    logic [ADDR_W-1:0] wr_addr = 8'h00;
    logic [DATA_W-1:0] wr_data = 24'h000000;
    logic [CRC_W-1:0] wr_checksum = 8'h00;
    logic cal_store = 1'b0;
    logic [MODE_W-1:0] mode = MODE_IDLE;
    logic streaming_readout_bit = 1'b0;
    logic [2:0] err_clear = 3'h0;
    logic [23:0] corrupt = 24'h000000;
    logic rom_bad = 1'b0;
    wire logic [7:0] mem_addr, rom_addr, rom_crc;
    wire logic [23:0] mem_rd_data, rom_data, enables;
    wire logic mem_rd_ro, spi_f, mm_f, rom_f;
    wire logic [23:0] obs [4];
    string nm [4] = '{"enables", "checksum_fault", "memory_fault", "rom_fault"};
    logic [25:0] exp_q [$];
    event chk_ev;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    assign obs[0] = enables;
    assign obs[1] = {23'h000000, spi_f};
    assign obs[2] = {23'h000000, mm_f};
    assign obs[3] = {23'h000000, rom_f};
    config_integrity_crc_checker #(.CHECK_CYC(CYC), .LOCS(LC), .ROM_LEN(4)) dut (
        .clk(clk), .rst(rst), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_checksum(wr_checksum), .cal_store(cal_store),
        .mode(mode), .streaming_readout_bit(streaming_readout_bit),
        .mem_addr(mem_addr), .mem_rd_data(mem_rd_data), .mem_rd_ro(mem_rd_ro),
        .rom_addr(rom_addr), .rom_data(rom_data), .rom_expected_crc(rom_crc),
        .err_clear(err_clear), .error_check_enables(enables),
        .spi_checksum_fault(spi_f), .config_memory_fault_flag(mm_f),
        .rom_fault_flag(rom_f));
    host_mem_model #(.ROM_LEN(4)) mdl (
        .clk(clk), .mem_addr(mem_addr), .rom_addr(rom_addr),
        .corrupt(corrupt), .rom_bad(rom_bad), .mem_rd_data(mem_rd_data),
        .mem_rd_ro(mem_rd_ro), .rom_data(rom_data),
        .rom_expected_crc(rom_crc));
    always #5 clk = ~clk;
    // Oldest note is matched against what the outputs show now
    always @(chk_ev) begin
        logic [25:0] e;
        e = exp_q.pop_front();
        checks++;
        if (obs[e[25:24]] !== e[23:0]) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm[e[25:24]], e[23:0],
                obs[e[25:24]]);
        end
    end
    task automatic chk(input logic [1:0] i, input logic [23:0] v);
        exp_q.push_back({i, v});
        ->chk_ev;
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d,
                      input logic bad);
        @(negedge clk);
        wr_valid = 1'b1;
        wr_addr = a;
        wr_data = d;
        wr_checksum = mdl.crc8(8'h00, {a, d}) ^ {7'h00, bad};
        @(negedge clk);
        wr_valid = 1'b0;
    endtask
    task automatic clr(input logic [2:0] m);
        @(negedge clk);
        err_clear = m;
        @(negedge clk);
        err_clear = 3'h0;
    endtask
    task automatic do_reset(input logic bad);
        rom_bad = bad;
        rst = 1'b1;
        idle(12);
        rst = 1'b0;
        idle(30);
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 1200 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(32'h7F52DBC9));
        do_reset(1'b0);
        chk(0, ENABLES_RESET);
        for (int i = 1; i < 4; i++) begin
            chk(2'(i), 24'h000000);
        end
        wr(ENABLES_ADDR, 24'h000001, 1'b0);
        idle(2);
        chk(3, 24'h000000);
        do_reset(1'b1);
        chk(3, 24'h000000);
        wr(ENABLES_ADDR, 24'h000001, 1'b0);
        idle(2);
        chk(3, 24'h000001);
        clr(3'h4);
        idle(2);
        chk(3, 24'h000001);
        wr(ENABLES_ADDR, 24'h000004, 1'b1);
        idle(1);
        chk(0, 24'h000004);
        chk(1, 24'h000000);
        wr(ENABLES_ADDR, 24'h000006, 1'b1);
        idle(1);
        chk(0, 24'h000004);
        chk(1, 24'h000001);
        clr(3'h5);
        idle(1);
        chk(1, 24'h000000);
        chk(3, 24'h000000);
        wr(ENABLES_ADDR, 24'h000006, 1'b0);
        // Host trusts a checked write only once the readback agrees
        chk(0, 24'h000006);
        idle(WAITC);
        chk(2, 24'h000000);
        corrupt = 24'h000100;
        idle(WAITC);
        chk(2, 24'h000001);
        // Each update event must adopt the altered word as the new reference
        for (int k = 0; k < 4; k++) begin
            corrupt = corrupt ^ (24'($urandom()) | 24'h000001);
            case (k)
                0: begin
                    cal_store = 1'b1;
                    idle(1);
                    cal_store = 1'b0;
                end
                1: begin
                    mode = MODE_SINGLE;
                    idle(1);
                    mode = MODE_IDLE;
                end
                2: begin
                    streaming_readout_bit = 1'b1;
                    idle(1);
                    streaming_readout_bit = 1'b0;
                end
                default: wr(8'h10, 24'($urandom()), 1'b0);
            endcase
            idle(LC + 6);
            clr(3'h2);
            idle(WAITC);
            chk(2, 24'h000000);
        end
        wr(ENABLES_ADDR, 24'h000004, 1'b0);
        idle(LC + 6);
        corrupt = ~corrupt;
        idle(WAITC);
        chk(2, 24'h000000);
        end_sim();
    end
endmodule // tb_config_integrity_crc_checker
`default_nettype wire
